// >>> hdl/pcs_pkg.sv
// Purpose: shared constants and types for the program flow and indirect access block
// Assumes: one core clock, asynchronous active-high reset
// Notes: none
package pcs_pkg;
  localparam int PC_WIDTH = 13;
  localparam int LOW_WIDTH = 8;
  localparam int HIGH_WIDTH = 5;
  localparam int TARGET_WIDTH = 11;
  localparam int TOP_WIDTH = 2;
  localparam int LATCH_TOP_LSB = 3;
  localparam int STACK_DEPTH = 8;
  localparam int STACK_PTR_WIDTH = 3;
  localparam int FILE_ADDR_WIDTH = 9;
  localparam logic [PC_WIDTH-1:0] PC_RESET = 13'h0000;
  localparam logic [PC_WIDTH-1:0] PC_STEP = 13'h0001;
  localparam logic [PC_WIDTH-1:0] INT_VECTOR = 13'h0004;
  localparam logic [LOW_WIDTH-1:0] SELF_POINTER = 8'h00;
  localparam logic [LOW_WIDTH-1:0] SELF_READ = 8'h00;
  localparam logic [STACK_PTR_WIDTH-1:0] PTR_STEP = 3'h1;
  localparam logic [STACK_PTR_WIDTH-1:0] PTR_RESET = 3'h0;

  typedef enum logic [2:0]
  {
    OP_STEP = 3'b000,
    OP_CALL = 3'b001,
    OP_JUMP = 3'b010,
    OP_RETURN = 3'b011,
    OP_RETURN_LITERAL = 3'b100,
    OP_RETURN_INTERRUPT = 3'b101,
    OP_INTERRUPT = 3'b110,
    OP_HOLD = 3'b111
  } pcs_flow_type;

  typedef struct packed
  {
    pcs_flow_type op;
    logic [TARGET_WIDTH-1:0] target;
    logic lowWrite;
    logic [LOW_WIDTH-1:0] lowData;
    logic [HIGH_WIDTH-1:0] highLatch;
  } pcs_flow_req_type;

  typedef struct packed
  {
    logic read;
    logic write;
    logic [LOW_WIDTH-1:0] wdata;
    logic [LOW_WIDTH-1:0] pointer;
    logic bankHigh;
  } pcs_ind_req_type;

  typedef struct packed
  {
    logic read;
    logic write;
    logic [FILE_ADDR_WIDTH-1:0] addr;
    logic [LOW_WIDTH-1:0] wdata;
  } pcs_file_req_type;

  function automatic logic [STACK_PTR_WIDTH-1:0] pcs_wrap_step(
    input logic [STACK_PTR_WIDTH-1:0] ptr, input logic up);
    pcs_wrap_step = up ? ptr + PTR_STEP : ptr - PTR_STEP;
  endfunction
endpackage

// >>> hdl/pcs_return_stack.sv
// Purpose: circular eight-entry return stack
// Assumes: push and pop never together
// Notes: pointer hidden, no overflow flag
`timescale 1ns/1ns
`default_nettype none
module pcs_return_stack
  import pcs_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic enable,
  input wire logic push,
  input wire logic pop,
  input wire logic [PC_WIDTH-1:0] pushData,
  output logic [PC_WIDTH-1:0] topData
);
  logic [PC_WIDTH-1:0] entries [STACK_DEPTH];
  logic [STACK_PTR_WIDTH-1:0] pointer;
  wire logic [STACK_PTR_WIDTH-1:0] popIndex = pcs_wrap_step(pointer, 1'b0);

  // pointer wraps silently both ways
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      pointer <= PTR_RESET;
    else if (enable && push)
      pointer <= pcs_wrap_step(pointer, 1'b1);
    else if (enable && pop)
      pointer <= popIndex;
  end

  always_ff @(posedge clock)
  begin
    if (enable && push)
      entries[pointer] <= pushData;
  end

  assign topData = entries[popIndex];
endmodule // pcs_return_stack
`default_nettype wire

// >>> hdl/pcs_flow_core.sv
// Purpose: program counter, return stack use and indirect data port
// Assumes: decode logic drives requests on the same clock
// Notes: counter outputs registered
`timescale 1ns/1ns
`default_nettype none
module pcs_flow_core
  import pcs_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic enable,
  input wire pcs_flow_req_type flowReq,
  input wire pcs_ind_req_type indReq,
  input wire logic [LOW_WIDTH-1:0] fileRdata,
  output logic [PC_WIDTH-1:0] programCounter,
  output logic [LOW_WIDTH-1:0] pcLowByte,
  output pcs_file_req_type fileReq,
  output logic [LOW_WIDTH-1:0] indRdata
);
  logic [PC_WIDTH-1:0] pc;
  logic [PC_WIDTH-1:0] next_pc;
  logic [PC_WIDTH-1:0] stackTop;

  wire logic isCall = flowReq.op == OP_CALL;
  wire logic isJump = flowReq.op == OP_JUMP;
  wire logic isReturn = flowReq.op == OP_RETURN || flowReq.op == OP_RETURN_LITERAL
    || flowReq.op == OP_RETURN_INTERRUPT;
  wire logic isInterrupt = flowReq.op == OP_INTERRUPT;
  wire logic doPush = isCall || isInterrupt;
  wire logic doPop = isReturn;
  wire logic [PC_WIDTH-1:0] pcPlusOne = pc + PC_STEP;
  wire logic [PC_WIDTH-1:0] lowWriteValue = {flowReq.highLatch, flowReq.lowData};
  wire logic [PC_WIDTH-1:0] branchValue =
    {flowReq.highLatch[HIGH_WIDTH-1:LATCH_TOP_LSB], flowReq.target};
  wire logic selfPointer = indReq.pointer == SELF_POINTER;
  wire logic [FILE_ADDR_WIDTH-1:0] indAddr = {indReq.bankHigh, indReq.pointer};
  wire logic stackPush = doPush && !flowReq.lowWrite;
  wire logic stackPop = doPop && !flowReq.lowWrite;
  wire logic [PC_WIDTH-1:0] returnAddress = isCall ? pcPlusOne : pc;

  always_comb
  begin
    next_pc = pc;
    if (flowReq.lowWrite)
      next_pc = lowWriteValue;
    else if (isCall || isJump)
      next_pc = branchValue;
    else if (isInterrupt)
      next_pc = INT_VECTOR;
    else if (doPop)
      next_pc = stackTop;
    else if (flowReq.op == OP_STEP)
      next_pc = pcPlusOne;
  end

  // push stores the return address
  pcs_return_stack pcs_return_stack_i
  (
    .clock(clock),
    .reset(reset),
    .enable(enable),
    .push(stackPush),
    .pop(stackPop),
    .pushData(returnAddress),
    .topData(stackTop)
  );

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      pc <= PC_RESET;
    else if (enable)
      pc <= next_pc;
  end

  assign programCounter = pc;
  assign pcLowByte = pc[LOW_WIDTH-1:0];

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      fileReq <= '0;
    else if (enable)
    begin
      fileReq.read <= indReq.read && !selfPointer;
      fileReq.write <= indReq.write && !selfPointer;
      fileReq.addr <= indAddr;
      fileReq.wdata <= indReq.wdata;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      indRdata <= SELF_READ;
    else if (enable && indReq.read)
      indRdata <= selfPointer ? SELF_READ : fileRdata;
  end

  AST_RESET_HIGH: assert property (@(posedge clock)
    $fell(reset)
    |-> pc[PC_WIDTH-1:LOW_WIDTH] == '0)
    else $error("upper counter bits not cleared");

  AST_RESET_IDLE: assert property (@(posedge clock)
    $fell(reset)
    |-> fileReq == '0 && indRdata == SELF_READ)
    else $error("file request not idle after reset");

  AST_LOW_WRITE: assert property (@(posedge clock) disable iff (reset)
    enable && flowReq.lowWrite
    |=> pc == $past(lowWriteValue))
    else $error("low write did not load latch");

  AST_BRANCH: assert property (@(posedge clock) disable iff (reset)
    enable && !flowReq.lowWrite && (isCall || isJump)
    |=> pc[PC_WIDTH-1:TARGET_WIDTH] == $past(flowReq.highLatch[HIGH_WIDTH-1:LATCH_TOP_LSB]))
    else $error("branch top bits wrong");

  AST_TARGET: assert property (@(posedge clock) disable iff (reset)
    enable && !flowReq.lowWrite && isJump
    |=> pc[TARGET_WIDTH-1:0] == $past(flowReq.target))
    else $error("branch target wrong");

  AST_CALL_TARGET: assert property (@(posedge clock) disable iff (reset)
    enable && !flowReq.lowWrite && isCall
    |=> pc[TARGET_WIDTH-1:0] == $past(flowReq.target))
    else $error("call target wrong");

  AST_INT_VECTOR: assert property (@(posedge clock) disable iff (reset)
    enable && !flowReq.lowWrite && isInterrupt
    |=> pc == INT_VECTOR)
    else $error("interrupt vector wrong");

  sequence callSeq;
    enable && !flowReq.lowWrite && isCall;
  endsequence

  sequence retSeq;
    enable && !flowReq.lowWrite && isReturn;
  endsequence

  sequence intSeq;
    enable && !flowReq.lowWrite && isInterrupt;
  endsequence

  AST_CALL_RETURN: assert property (@(posedge clock) disable iff (reset)
    callSeq ##1 retSeq
    |=> pc == $past(pc, 2) + PC_STEP)
    else $error("return address wrong");

  AST_INT_RETURN: assert property (@(posedge clock) disable iff (reset)
    intSeq ##1 retSeq
    |=> pc == $past(pc, 2))
    else $error("interrupt return address wrong");

  AST_NEST_RETURN: assert property (@(posedge clock) disable iff (reset)
    callSeq ##1 callSeq ##1 retSeq ##1 retSeq
    |=> pc == $past(pc, 4) + PC_STEP)
    else $error("nested return address wrong");

  AST_HOLD: assert property (@(posedge clock) disable iff (reset)
    enable && !flowReq.lowWrite && flowReq.op == OP_HOLD
    |=> pc == $past(pc))
    else $error("hold changed counter");

  AST_FREEZE_PC: assert property (@(posedge clock) disable iff (reset)
    !enable
    |=> pc == $past(pc))
    else $error("counter moved while disabled");

  AST_FREEZE_PORT: assert property (@(posedge clock) disable iff (reset)
    !enable
    |=> fileReq == $past(fileReq) && indRdata == $past(indRdata))
    else $error("indirect port moved while disabled");

  AST_UPPER_KEEP: assert property (@(posedge clock) disable iff (reset)
    enable && !flowReq.lowWrite && flowReq.op == OP_STEP && !(&pc[LOW_WIDTH-1:0])
    |=> pc[PC_WIDTH-1:LOW_WIDTH] == $past(pc[PC_WIDTH-1:LOW_WIDTH]))
    else $error("upper bits changed without cause");

  AST_STEP: assert property (@(posedge clock) disable iff (reset)
    enable && !flowReq.lowWrite && flowReq.op == OP_STEP
    |=> pc == $past(pcPlusOne))
    else $error("counter did not step");

  AST_SELF_READ: assert property (@(posedge clock) disable iff (reset)
    enable && indReq.read && selfPointer
    |=> indRdata == SELF_READ)
    else $error("self read not zero");

  AST_SELF_NO_READ: assert property (@(posedge clock) disable iff (reset)
    enable && indReq.read && selfPointer
    |=> !fileReq.read)
    else $error("self read reached file");

  AST_SELF_WRITE: assert property (@(posedge clock) disable iff (reset)
    enable && indReq.write && selfPointer
    |=> !fileReq.write)
    else $error("self write reached file");

  AST_IND_ADDR: assert property (@(posedge clock) disable iff (reset)
    enable && indReq.read && !selfPointer
    |=> fileReq.read && fileReq.addr == $past(indAddr))
    else $error("indirect address wrong");

  AST_WRITE_PASS: assert property (@(posedge clock) disable iff (reset)
    enable && indReq.write && !selfPointer
    |=> fileReq.write && fileReq.addr == $past(indAddr) && fileReq.wdata == $past(indReq.wdata))
    else $error("indirect write not passed on");

  AST_READ_DATA: assert property (@(posedge clock) disable iff (reset)
    enable && indReq.read && !selfPointer
    |=> indRdata == $past(fileRdata))
    else $error("indirect read data wrong");

  AST_RDATA_HOLD: assert property (@(posedge clock) disable iff (reset)
    enable && !indReq.read
    |=> indRdata == $past(indRdata))
    else $error("read data changed without read");

  AST_NO_STRAY: assert property (@(posedge clock) disable iff (reset)
    enable && !indReq.read && !indReq.write
    |=> !fileReq.read && !fileReq.write)
    else $error("file access without request");

  AST_BANK_TOP: assert property (@(posedge clock) disable iff (reset)
    enable && (indReq.read || indReq.write)
    |=> fileReq.addr[FILE_ADDR_WIDTH-1] == $past(indReq.bankHigh))
    else $error("bank select bit not on top");
endmodule // pcs_flow_core
`default_nettype wire

// >>> verification/pcs_file_model.sv
// Purpose: file register model behind the indirect port
// Assumes: reads answered in the same cycle
// Notes: contents start from a fixed pattern
`timescale 1ns/1ns
`default_nettype none
module pcs_file_model
  import pcs_pkg::*;
(
  input wire logic clock,
  input wire pcs_ind_req_type indReq,
  input wire pcs_file_req_type fileReq,
  output logic [LOW_WIDTH-1:0] fileRdata
);
  logic [7:0] mem [512];
  initial
  begin
    for (int a = 0; a < 512; a++)
      mem[a] = 8'h35 ^ a[7:0] ^ {a[8], 7'h00};
  end
  assign fileRdata = mem[{indReq.bankHigh, indReq.pointer}];
  always @(posedge clock)
  begin
    if (fileReq.write)
      mem[fileReq.addr] <= fileReq.wdata;
  end
endmodule // pcs_file_model
`default_nettype wire

// >>> verification/pc_stack_indirect_addressing_test.sv
// Purpose: random and corner tests of counter, stack and indirect port
// Assumes: inputs driven on the falling edge
// Notes: expected counter and stack kept in the bench
`timescale 1ns/1ns
`default_nettype none
module pc_stack_indirect_addressing_test;
  import pcs_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic enable = 1'b1;
  pcs_flow_req_type flowReq = '0;
  pcs_ind_req_type indReq = '0;
  logic [7:0] fileRdata, pcLowByte, indRdata;
  logic [12:0] programCounter;
  pcs_file_req_type fileReq;
  logic [12:0] expPc = '0;
  logic [12:0] stk [8];
  logic [2:0] sp = '0;
  logic [7:0] bm [512];
  int failures = 0;
  int num_checks = 0;
  always #50 clock = ~clock;
  pcs_flow_core pcs_flow_core_i (.clock(clock), .reset(reset), .enable(enable),
    .flowReq(flowReq), .indReq(indReq), .fileRdata(fileRdata),
    .programCounter(programCounter), .pcLowByte(pcLowByte), .fileReq(fileReq),
    .indRdata(indRdata));
  pcs_file_model pcs_file_model_i (.clock(clock), .indReq(indReq), .fileReq(fileReq),
    .fileRdata(fileRdata));
  task automatic chk(input string n, input logic [12:0] e, input logic [12:0] s);
    num_checks++;
    if (s !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick();
    @(posedge clock);
    @(negedge clock);
  endtask
  task automatic flow(input pcs_flow_type op, input logic [10:0] t, input logic w,
    input logic [7:0] d, input logic [4:0] h);
    flowReq = '{op, t, w, d, h};
    if (w)
      expPc = {h, d};
    else if (op == OP_CALL || op == OP_INTERRUPT)
    begin
      stk[sp] = (op == OP_CALL) ? expPc + 13'h0001 : expPc;
      sp++;
      expPc = (op == OP_CALL) ? {h[4:3], t} : INT_VECTOR;
    end
    else if (op == OP_JUMP)
      expPc = {h[4:3], t};
    else if (op inside {OP_RETURN, OP_RETURN_LITERAL, OP_RETURN_INTERRUPT})
    begin
      sp--;
      expPc = stk[sp];
    end
    else if (op == OP_STEP)
      expPc = expPc + 13'h0001;
    tick();
    chk("pc", expPc, programCounter);
    chk("pcLow", {5'h00, expPc[7:0]}, {5'h00, pcLowByte});
  endtask
  task automatic ind(input logic w, input logic [7:0] d, input logic [7:0] p, input logic b);
    logic [8:0] a;
    a = {b, p};
    indReq = '{~w, w, d, p, b};
    tick();
    indReq = '0;
    chk("wr", {12'h000, w && p != 8'h00}, {12'h000, fileReq.write});
    chk("rdreq", {12'h000, !w && p != 8'h00}, {12'h000, fileReq.read});
    if (p != 8'h00)
      chk("addr", {4'h0, a}, {4'h0, fileReq.addr});
    if (w && p != 8'h00)
    begin
      chk("wdata", {5'h00, d}, {5'h00, fileReq.wdata});
      bm[a] = d;
      tick();
    end
    if (!w)
      chk("rd", (p == 8'h00) ? 13'h0000 : {5'h00, bm[a]}, {5'h00, indRdata});
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    for (int a = 0; a < 512; a++)
      bm[a] = 8'h35 ^ a[7:0] ^ {a[8], 7'h00};
    void'($urandom(60378));
    repeat (4) @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    flow(OP_STEP, 11'h000, 1'b1, 8'ha5, 5'h1f);
    flow(OP_STEP, 11'h000, 1'b0, 8'h00, 5'h00);
    flow(OP_JUMP, 11'h7ff, 1'b0, 8'h00, 5'h10);
    flow(OP_CALL, 11'h123, 1'b1, 8'h5a, 5'h0a);
    flow(OP_STEP, 11'h000, 1'b1, expPc[7:0] + 8'hc0, expPc[12:8]);
    $display("test load and jump done");
    for (int i = 0; i < 9; i++)
      flow(OP_CALL, 11'(i * 229), 1'b0, 8'h00, 5'(i * 3));
    for (int i = 0; i < 10; i++)
      flow(pcs_flow_type'(3 + i % 3), 11'h000, 1'b0, 8'h00, 5'h00);
    flow(OP_INTERRUPT, 11'h000, 1'b0, 8'h00, 5'h00);
    flow(OP_RETURN_INTERRUPT, 11'h000, 1'b0, 8'h00, 5'h00);
    $display("test stack done");
    for (int i = 0; i < 200; i++)
      flow(pcs_flow_type'($urandom_range(0, 7)), 11'($urandom), $urandom_range(0, 3) == 0,
        8'($urandom), 5'($urandom));
    flow(OP_HOLD, 11'h000, 1'b0, 8'h00, 5'h00);
    $display("test random flow done");
    ind(1'b0, 8'h00, 8'h05, 1'b0);
    ind(1'b1, 8'h3c, 8'h00, 1'b0);
    ind(1'b0, 8'h00, 8'h00, 1'b1);
    ind(1'b1, 8'hc3, 8'h80, 1'b1);
    ind(1'b0, 8'h00, 8'h80, 1'b1);
    ind(1'b0, 8'h00, 8'h80, 1'b0);
    for (int i = 0; i < 60; i++)
      ind($urandom_range(0, 1), 8'($urandom), ($urandom_range(0, 4) == 0) ? 8'h00 : 8'($urandom),
        $urandom_range(0, 1));
    $display("test indirect done");
    enable = 1'b0;
    flowReq.op = OP_CALL;
    tick();
    chk("pc", expPc, programCounter);
    enable = 1'b1;
    flow(OP_STEP, 11'h000, 1'b1, 8'hff, 5'h1f);
    reset = 1'b1;
    @(negedge clock);
    chk("pc", 13'h0000, programCounter);
    $display("test enable and reset done");
    print_verdict();
  end
endmodule // pc_stack_indirect_addressing_test
`default_nettype wire
